// ---- verilog/wdw_defines.svh ----
// Constants for the watchdog and wake-up control block.
// Assumes inclusion by the top module only.
`ifndef WDW_DEFINES_SVH
`define WDW_DEFINES_SVH
// ==========================================================
// Register byte addresses (AXI4-Lite, one word each)
`define WDW_ADDR_WATCHDOG_CONTROL 4'h0
`define WDW_ADDR_SYSC 4'h4
`define WDW_ADDR_STAT 4'h8
`define WDW_ADDR_CMD 4'hC
// ==========================================================
// Reset values and key codes
`define WDW_WATCHDOG_CONTROL_RESET 8'h53
`define WDW_KEY_DIS 5'h15
`define WDW_KEY_EN 5'h0A
// ==========================================================
// Field positions
`define WDW_SYSC_SYSON 7
`define WDW_SYSC_WRF 0
`define WDW_CMD_CLR 0
`define WDW_CMD_SLEEP 1
`define WDW_CMD_IDLE 2
`define WDW_CMD_DEEP 3
// ==========================================================
// Timing
`define WDW_CLK_HZ 125000000
`define WDW_SUB_HZ 32000
`define WDW_SUB_DIV (`WDW_CLK_HZ / `WDW_SUB_HZ)
`define WDW_KEY_DELAY 2'h2
`define WDW_AXI_OKAY 2'h0
`define WDW_AXI_DECERR 2'h3
`endif

// ---- verilog/wdw_pkg.sv ----
// Types for the watchdog and wake-up control block.
// Assumes the defines header is compiled alongside.
package wdw_pkg;
    // ======================================================
    // Power mode states
    typedef enum logic [4:0] {
        WDW_RUN = 5'b00001,
        WDW_IDLE = 5'b00010,
        WDW_SLEEP = 5'b00100,
        WDW_HSTART = 5'b01000,
        WDW_LSTART = 5'b10000
    } wdw_mode_t;
    // ======================================================
    // Reset requests toward the core
    typedef struct packed {
        logic full;
        logic pc_sp;
    } wdw_rst_t;
endpackage : wdw_pkg

// ---- verilog/wdw_top.sv ----
// Watchdog, key check, power-down flags and wake-up sequencing.
// Assumes a single 125 MHz clock and an AXI4-Lite master.
`timescale 1ns/1ps
`default_nettype none
`include "wdw_defines.svh"
// Overview of operation
// (R01) Leave sleep or idle on reset, port fall, interrupt or overflow.
// (R02) Reset wake is full reset; overflow wake is a watchdog reset.
// (R03) Power-down flag cleared on power-up or clear; set on sleep.
// (R04) Enabled port pins wake on falling edge; resume after sleep.
// (R05) Disabled or stack-full interrupt wakes; stays pending, resume after.
// (R06) Enabled interrupt with stack room is serviced on wake.
// (R07) Interrupt already pending before sleep cannot wake the device.
// (R08) One start-up timer; low start counts after high start ends.
// (R09) From deep sleep, run only after high oscillator ready.
// (R10) Watchdog counts sub clock ticks near 32 kHz.
// (R11) Timeout select picks 2^8 to 2^18 sub clock cycles.
// (R12) Key 10101 disables, 01010 enables, else reset after 2-3 ticks.
// (R13) Key powers up as 01010, watchdog enabled.
// (R14) Invalid key sets key reset flag; only software 0 clears.
// (R15) Timeout resets in run; in sleep resets PC and SP only.
// (R16) Count cleared by key reset, clear instruction or sleep.
// (R17) Idle clock bit keeps system clock on in idle.
// (R18) Control bits 6 to 3 read as zero.
// (R19) Low clock runs only while watchdog enabled or key invalid.
// (R20) Power-on reset leaves program counter at zero.
// (R21) Sleep sets power-down flag and clears timeout flag.
// (R22) Free count of sub ticks overflows at chosen ratio, restarts.
module wdw_top #(
    parameter int PORT_W = 8,
    parameter int INT_W = 4,
    parameter int SUB_DIV = `WDW_SUB_DIV,
    parameter int HSTART_TICKS = 1024,
    parameter int LSTART_TICKS = 1024
) (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic [3:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [3:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY,
    input wire logic EXT_RESET,
    input wire logic [PORT_W-1:0] PORT_PINS,
    input wire logic [PORT_W-1:0] PORT_WAKE_EN,
    input wire logic [INT_W-1:0] INT_REQ,
    input wire logic [INT_W-1:0] INT_EN,
    input wire logic STACK_FULL,
    output logic CORE_RUN,
    output logic SERVICE_INT,
    output logic [INT_W-1:0] INT_PENDING,
    output wdw_pkg::wdw_rst_t CORE_RST,
    output logic PC_ZERO,
    output logic SYSCLK_ON,
    output logic LOW_OSC_ON,
    output logic HIGH_OSC_READY
);
    // ======================================================
    // Elaboration checks
    if (PORT_W < 1 || INT_W < 1 || SUB_DIV < 2 ||
        HSTART_TICKS < 1 || LSTART_TICKS < 1) begin : g_bad
        $error("wdw_top: bad parameter");
    end

    // ======================================================
    // Register state
    logic [7:0] watchdog_control;
    logic idle_sysclk_on;
    logic wdt_key_reset_flag;
    logic power_down_flag;
    logic timeout_flag;
    wdw_pkg::wdw_mode_t mode;
    logic deep;
    logic [18:0] wdt_cnt;
    logic [31:0] div_cnt;
    logic sub_tick;
    logic [1:0] key_cnt;
    logic [PORT_W-1:0] port_q;
    logic [INT_W-1:0] int_q;
    logic [INT_W-1:0] int_masked;
    logic [31:0] sst_cnt;
    logic pc_zero;

    // ======================================================
    // Bus decode
    logic aw_ok;
    logic w_go;
    logic ar_go;
    logic [31:0] wd;
    assign w_go = AWVALID && WVALID && !BVALID;
    assign AWREADY = w_go;
    assign WREADY = w_go;
    assign ar_go = ARVALID && !RVALID;
    assign ARREADY = ar_go;
    assign wd = WDATA;
    assign aw_ok = (AWADDR == `WDW_ADDR_WATCHDOG_CONTROL) || (AWADDR == `WDW_ADDR_SYSC) ||
                   (AWADDR == `WDW_ADDR_CMD);
    wire wr_watchdog_control = w_go && AWADDR == `WDW_ADDR_WATCHDOG_CONTROL && WSTRB[0];
    wire wr_sysc = w_go && AWADDR == `WDW_ADDR_SYSC && WSTRB[0];
    wire wr_cmd = w_go && AWADDR == `WDW_ADDR_CMD && WSTRB[0];
    wire cmd_clr = wr_cmd && wd[`WDW_CMD_CLR];
    wire cmd_halt = wr_cmd && (wd[`WDW_CMD_SLEEP] || wd[`WDW_CMD_IDLE]) &&
                    mode == wdw_pkg::WDW_RUN;

    // ======================================================
    // Watchdog key and timeout
    wire [4:0] key = watchdog_control[7:3];
    wire key_bad = key != `WDW_KEY_DIS && key != `WDW_KEY_EN;  // [R12]
    wire wdt_on = key == `WDW_KEY_EN;                           // [R12]
    wire key_fire = key_bad && sub_tick && key_cnt == `WDW_KEY_DELAY;
    logic [18:0] limit;
    always_comb begin
        case (watchdog_control[2:0])                                        // [R11]
            3'h0: limit = 19'h00100;
            3'h1: limit = 19'h00400;
            3'h2: limit = 19'h01000;
            3'h3: limit = 19'h04000;
            3'h4: limit = 19'h08000;
            3'h5: limit = 19'h10000;
            3'h6: limit = 19'h20000;
            default: limit = 19'h40000;
        endcase
    end
    wire overflow = wdt_on && sub_tick && (wdt_cnt + 19'h1 == limit); // [R22]
    wire asleep = mode != wdw_pkg::WDW_RUN;

    // ======================================================
    // Wake sources
    wire port_fall = |(port_q & ~PORT_PINS & PORT_WAKE_EN);     // [R04]
    wire int_wake = |(INT_REQ & ~int_masked);                   // [R07]
    wire wake = EXT_RESET || port_fall || int_wake || overflow; // [R01]
    wire in_hold = mode == wdw_pkg::WDW_IDLE || mode == wdw_pkg::WDW_SLEEP;

    // Sub clock divider; stops when the key disables the watchdog, to save power
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            div_cnt <= 32'h0;
            sub_tick <= 1'b0;
        end else if (LOW_OSC_ON) begin                          // [R10]
            sub_tick <= div_cnt == 32'(SUB_DIV - 1);
            div_cnt <= (div_cnt == 32'(SUB_DIV - 1)) ? 32'h0 : div_cnt + 32'h1;
        end else begin
            sub_tick <= 1'b0;
        end
    end

    // Key check delay; counts sub ticks only while the key is bad
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            key_cnt <= 2'h0;
        end else if (!key_bad) begin
            key_cnt <= 2'h0;
        end else if (sub_tick) begin
            key_cnt <= key_cnt + 2'h1;                          // [R12]
        end
    end

    // Watchdog count; held at zero while disabled
    wire wdt_clear = key_fire || cmd_clr || cmd_halt || overflow || !wdt_on;
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            wdt_cnt <= 19'h0;
        end else if (wdt_clear) begin
            wdt_cnt <= 19'h0;                                   // [R16]
        end else if (sub_tick) begin
            wdt_cnt <= wdt_cnt + 19'h1;                         // [R22]
        end
    end

    // ======================================================
    // Registers and flags
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            watchdog_control <= `WDW_WATCHDOG_CONTROL_RESET;                            // [R13]
        end else if (key_fire) begin
            // Invalid key reloads the power-on value
            watchdog_control <= `WDW_WATCHDOG_CONTROL_RESET;
        end else if (wr_watchdog_control) begin
            watchdog_control <= wd[7:0];
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            idle_sysclk_on <= 1'b0;
        end else if (wr_sysc) begin
            idle_sysclk_on <= wd[`WDW_SYSC_SYSON];              // [R17]
        end
    end

    // Set beats a same-cycle software clear; writing 1 does nothing
    wire wrf_clr = wr_sysc && !wd[`WDW_SYSC_WRF];
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            wdt_key_reset_flag <= 1'b0;
        end else if (key_fire) begin
            wdt_key_reset_flag <= 1'b1;                         // [R14]
        end else if (wrf_clr) begin
            wdt_key_reset_flag <= 1'b0;
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            power_down_flag <= 1'b0;                            // [R03]
        end else if (cmd_halt) begin
            power_down_flag <= 1'b1;                            // [R21]
        end else if (cmd_clr) begin
            power_down_flag <= 1'b0;                            // [R03]
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            timeout_flag <= 1'b0;
        end else if (overflow) begin
            timeout_flag <= 1'b1;                               // [R15]
        end else if (cmd_halt) begin
            timeout_flag <= 1'b0;                               // [R21]
        end
    end

    // ======================================================
    // Pin and request history for edge and mask detection
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            port_q <= '0;
            int_q <= '0;
        end else begin
            port_q <= PORT_PINS;
            int_q <= INT_REQ & INT_EN;
        end
    end

    // Start address flag; drops after the first running cycle
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            pc_zero <= 1'b1;                                    // [R20]
        end else if (CORE_RUN) begin
            pc_zero <= 1'b0;
        end
    end

    // ======================================================
    // Power mode sequencing
    wire hs_done = sst_cnt == 32'(HSTART_TICKS - 1);
    wire ls_done = sst_cnt == 32'(LSTART_TICKS - 1);
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            mode <= wdw_pkg::WDW_RUN;
            deep <= 1'b0;
            sst_cnt <= 32'h0;
            int_masked <= '0;
        end else begin
            case (mode)
                wdw_pkg::WDW_RUN: begin
                    sst_cnt <= 32'h0;
                    if (cmd_halt) begin
                        int_masked <= INT_REQ;                  // [R07]
                        deep <= wd[`WDW_CMD_DEEP];
                        mode <= wd[`WDW_CMD_IDLE] ?
                            wdw_pkg::WDW_IDLE : wdw_pkg::WDW_SLEEP;
                    end
                end
                wdw_pkg::WDW_IDLE, wdw_pkg::WDW_SLEEP: begin
                    if (wake)
                        mode <= deep ? wdw_pkg::WDW_HSTART
                                     : wdw_pkg::WDW_RUN;        // [R01]
                end
                wdw_pkg::WDW_HSTART: begin
                    // High start first, then the shared count restarts
                    sst_cnt <= hs_done ? 32'h0 : sst_cnt + 32'h1; // [R08]
                    if (hs_done) mode <= wdw_pkg::WDW_LSTART;
                end
                wdw_pkg::WDW_LSTART: begin
                    sst_cnt <= ls_done ? 32'h0 : sst_cnt + 32'h1; // [R08]
                    if (ls_done) begin
                        mode <= wdw_pkg::WDW_RUN;
                        deep <= 1'b0;
                    end
                end
                default: mode <= wdw_pkg::WDW_RUN;
            endcase
        end
    end

    // ======================================================
    // Core facing outputs
    assign HIGH_OSC_READY = mode != wdw_pkg::WDW_HSTART &&
                            !(mode == wdw_pkg::WDW_SLEEP && deep);
    assign CORE_RUN = mode == wdw_pkg::WDW_RUN && HIGH_OSC_READY; // [R09]
    assign SYSCLK_ON = mode == wdw_pkg::WDW_RUN ||
        (mode == wdw_pkg::WDW_IDLE && idle_sysclk_on);          // [R17]
    assign LOW_OSC_ON = wdt_on || key_bad;                      // [R19]
    // Pending mirrors the raw request, whatever its enable or stack room
    assign INT_PENDING = INT_REQ;                               // [R05]
    assign SERVICE_INT = CORE_RUN && |int_q && !STACK_FULL;     // [R06]
    assign PC_ZERO = pc_zero;
    assign CORE_RST.full = (EXT_RESET) || key_fire ||
        (overflow && !asleep);                                  // [R02] [R15]
    assign CORE_RST.pc_sp = overflow && in_hold;                // [R15]

    // ======================================================
    // Read selection
    wire rd_watchdog_control = ARADDR == `WDW_ADDR_WATCHDOG_CONTROL;
    wire rd_sysc = ARADDR == `WDW_ADDR_SYSC;
    wire rd_stat = ARADDR == `WDW_ADDR_STAT;
    wire rd_cmd = ARADDR == `WDW_ADDR_CMD;
    wire rd_hit = rd_watchdog_control || rd_sysc || rd_stat || rd_cmd;
    // Unused control bits are tied low in the word itself
    wire [31:0] sysc_word = {24'h0, idle_sysclk_on, 4'h0, 2'h0,
                             wdt_key_reset_flag};               // [R18]
    wire [31:0] stat_word = {24'h0, 3'h0, mode};
    wire [31:0] cmd_word = {28'h0, 2'h0, timeout_flag, power_down_flag};
    wire [31:0] rd_word = rd_watchdog_control ? {24'h0, watchdog_control} :
                          rd_sysc ? sysc_word :
                          rd_stat ? stat_word :
                          rd_cmd ? cmd_word : 32'h0;

    // ======================================================
    // Bus answers
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            BVALID <= 1'b0;
            BRESP <= `WDW_AXI_OKAY;
        end else if (w_go) begin
            BVALID <= 1'b1;
            BRESP <= aw_ok ? `WDW_AXI_OKAY : `WDW_AXI_DECERR;
        end else if (BREADY) begin
            BVALID <= 1'b0;
        end
    end

    // Read data is captured once and stands until the handshake
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            RVALID <= 1'b0;
            RRESP <= `WDW_AXI_OKAY;
            RDATA <= 32'h0;
        end else if (ar_go) begin
            RVALID <= 1'b1;
            RRESP <= rd_hit ? `WDW_AXI_OKAY : `WDW_AXI_DECERR;
            RDATA <= rd_word;
        end else if (RREADY) begin
            RVALID <= 1'b0;
        end
    end
endmodule : wdw_top
`default_nettype wire

// ---- tb/wdw_checker.sv ----
// Port assertions for the watchdog and wake-up block.
// Assumes binding to wdw_top, one clock and an active-low reset.
`timescale 1ns/1ps
`default_nettype none
module wdw_checker (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic AWVALID,
    input wire logic WVALID,
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic ARVALID,
    input wire logic RVALID,
    input wire logic EXT_RESET,
    input wire logic STACK_FULL,
    input wire logic CORE_RUN,
    input wire logic SERVICE_INT,
    input wire wdw_pkg::wdw_rst_t CORE_RST,
    input wire logic SYSCLK_ON,
    input wire logic HIGH_OSC_READY
);
    // ==========================================================
    // Relations
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    chk_write_answer: assert property (AWVALID && WVALID && !BVALID |=> BVALID)
        else $error("write not answered");
    chk_bresp_holds: assert property (BVALID && !BREADY |=> BVALID)
        else $error("write answer dropped");
    chk_read_answer: assert property (ARVALID && !RVALID |=> RVALID)
        else $error("read not answered");
    chk_ext_full: assert property (EXT_RESET |-> CORE_RST.full)
        else $error("external reset not passed on");
    chk_run_sysclk: assert property (CORE_RUN |-> SYSCLK_ON)
        else $error("core runs without clock");
    chk_service_gate: assert property (
        SERVICE_INT |-> CORE_RUN && !STACK_FULL)
        else $error("service with stack full or halted");
    chk_pcsp_pulse: assert property (CORE_RST.pc_sp |=> !CORE_RST.pc_sp)
        else $error("short reset longer than a cycle");
    chk_pcsp_halted: assert property (CORE_RST.pc_sp |-> !CORE_RUN)
        else $error("short reset while running");
    chk_run_ready: assert property (CORE_RUN |-> HIGH_OSC_READY)
        else $error("core runs before oscillator ready");
    cov_pcsp: cover property (CORE_RST.pc_sp);
    cov_service: cover property (SERVICE_INT);
    cov_full: cover property (CORE_RST.full && !EXT_RESET);
endmodule : wdw_checker
bind wdw_top wdw_checker u_chk (.MCLK, .RSTN, .AWVALID, .WVALID, .BVALID,
    .BREADY, .ARVALID, .RVALID, .EXT_RESET, .STACK_FULL, .CORE_RUN,
    .SERVICE_INT, .CORE_RST, .SYSCLK_ON, .HIGH_OSC_READY);
`default_nettype wire

// ---- tb/wdw_bench.sv ----
// Self-checking bench for the watchdog and wake-up block.
// Assumes short sub tick and start-up counts set below.
`timescale 1ns/1ps
`default_nettype none
module wdw_bench;
    logic MCLK = 1'h0;
    logic RSTN = 1'h0;
    logic [3:0] AWADDR = 4'h0, ARADDR = 4'h0, WSTRB = 4'hF;
    logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0;
    logic ARVALID = 1'h0, RREADY = 1'h0;
    logic [31:0] WDATA = 32'h0, RDATA, r;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [1:0] BRESP, RRESP;
    logic EXT_RESET = 1'h0, STACK_FULL = 1'h0;
    logic [7:0] PORT_PINS = 8'hFF, PORT_WAKE_EN = 8'h01;
    logic [3:0] INT_REQ = 4'h0, INT_EN = 4'h2, INT_PENDING;
    logic CORE_RUN, SERVICE_INT, PC_ZERO, SYSCLK_ON, LOW_OSC_ON;
    logic HIGH_OSC_READY;
    wdw_pkg::wdw_rst_t CORE_RST;
    int n_errors = 0, tests_run = 0, n;
    always #4 MCLK = ~MCLK;
    wdw_top #(.SUB_DIV(4), .HSTART_TICKS(4), .LSTART_TICKS(4)) DUT (
        .MCLK, .RSTN, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID,
        .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID, .ARREADY,
        .RDATA, .RRESP, .RVALID, .RREADY, .EXT_RESET, .PORT_PINS,
        .PORT_WAKE_EN, .INT_REQ, .INT_EN, .STACK_FULL, .CORE_RUN,
        .SERVICE_INT, .INT_PENDING, .CORE_RST, .PC_ZERO, .SYSCLK_ON,
        .LOW_OSC_ON, .HIGH_OSC_READY);
    // ==========================================================
    // Shared tasks
    task close_out;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out
    task cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : cmp
    // Polls at falling edges, so inputs launched on rising edges are settled
    task wait_on(input int sel, input int lim, output int c);
        c = 0;
        while (!(sel == 0 ? CORE_RUN : sel == 1 ? CORE_RST.full :
                sel == 2 ? CORE_RST.pc_sp : sel == 3 ? AWREADY && WREADY :
                sel == 4 ? BVALID : sel == 5 ? ARREADY : RVALID)) begin
            @(negedge MCLK);
            c++;
            if (c > lim) begin
                n_errors++;
                $display("CHECK FAILED %0t wait timed out", $time);
                close_out();
            end
        end
    endtask : wait_on
    task wr(input logic [3:0] a, input logic [7:0] d);
        int k;
        @(posedge MCLK);
        AWADDR <= a;
        WDATA <= {24'h0, d};
        AWVALID <= 1'h1;
        WVALID <= 1'h1;
        BREADY <= 1'h1;
        @(negedge MCLK);
        wait_on(3, 50, k);
        @(posedge MCLK);
        AWVALID <= 1'h0;
        WVALID <= 1'h0;
        @(negedge MCLK);
        wait_on(4, 50, k);
        cmp({30'h0, BRESP}, 32'h0, "write response");
        @(posedge MCLK);
        BREADY <= 1'h0;
    endtask : wr
    task rd(input logic [3:0] a, output logic [31:0] d);
        int k;
        @(posedge MCLK);
        ARADDR <= a;
        ARVALID <= 1'h1;
        RREADY <= 1'h1;
        @(negedge MCLK);
        wait_on(5, 50, k);
        @(posedge MCLK);
        ARVALID <= 1'h0;
        @(negedge MCLK);
        wait_on(6, 50, k);
        d = RDATA;
        cmp({30'h0, RRESP}, 32'h0, "read response");
        @(posedge MCLK);
        RREADY <= 1'h0;
    endtask : rd
    task port_wake;
        PORT_PINS <= 8'hFE;
        wait_on(0, 50, n);
        @(posedge MCLK);
        PORT_PINS <= 8'hFF;
    endtask : port_wake
    // ==========================================================
    // Scenarios
    task s_regs;
        rd(4'h0, r);
        cmp(r, 32'h53, "control reset value");
        cmp(LOW_OSC_ON, 32'h1, "low clock on");
        cmp(PC_ZERO, 32'h0, "start flag released");
        wr(4'h4, 8'hFF);
        rd(4'h4, r);
        cmp(r, 32'h80, "flag register bits");
        wr(4'hC, 8'h04);
        cmp({SYSCLK_ON, CORE_RUN}, 32'h2, "idle keeps clock");
        port_wake();
        wr(4'h4, 8'h00);
    endtask : s_regs
    task s_sleep;
        INT_REQ <= 4'h1;
        wr(4'hC, 8'h02);
        rd(4'hC, r);
        cmp(r, 32'h1, "sleep flags");
        repeat (12) @(posedge MCLK);
        cmp({SYSCLK_ON, CORE_RUN}, 32'h0, "early request no wake");
        port_wake();
        INT_REQ <= 4'h0;
        wr(4'hC, 8'h01);
        rd(4'hC, r);
        cmp(r, 32'h0, "clear drops power-down");
    endtask : s_sleep
    task s_int;
        STACK_FULL <= 1'h1;
        wr(4'hC, 8'h02);
        INT_REQ <= 4'h2;
        wait_on(0, 50, n);
        @(negedge MCLK);
        cmp({SERVICE_INT, INT_PENDING}, 32'h2, "held while stack full");
        @(posedge MCLK);
        STACK_FULL <= 1'h0;
        @(negedge MCLK);
        cmp(SERVICE_INT, 32'h1, "serviced once stack frees");
        @(posedge MCLK);
        INT_REQ <= 4'h0;
    endtask : s_int
    task s_timeout;
        wr(4'h0, 8'h50);
        wr(4'hC, 8'h01);
        wait_on(1, 1100, n);
        cmp(n >= 1010 && n <= 1035, 32'h1, "run timeout length");
        wr(4'hC, 8'h04);
        wait_on(2, 1100, n);
        cmp(n >= 1010 && n <= 1035, 32'h1, "idle timeout");
        rd(4'hC, r);
        cmp(r, 32'h3, "timeout flag set");
        wr(4'h0, 8'hA8);
        cmp(LOW_OSC_ON, 32'h0, "low clock off");
        port_wake();
    endtask : s_timeout
    task s_key;
        wr(4'h0, 8'h00);
        wait_on(1, 40, n);
        cmp(n >= 4 && n <= 16, 32'h1, "bad key reset delay");
        rd(4'h4, r);
        cmp(r, 32'h1, "key reset flag");
        rd(4'h0, r);
        cmp(r, 32'h53, "control reloaded");
        wr(4'h4, 8'h00);
        rd(4'h4, r);
        cmp(r, 32'h0, "flag cleared by zero");
    endtask : s_key
    task s_deep;
        wr(4'h0, 8'hA8);
        wr(4'hC, 8'h0A);
        cmp(HIGH_OSC_READY, 32'h0, "oscillator off in deep");
        port_wake();
        cmp(n, 32'hA, "deep wake start-up length");
        rd(4'h8, r);
        cmp(r, 32'h1, "back in run");
        wr(4'hC, 8'h02);
        EXT_RESET <= 1'h1;
        wait_on(0, 50, n);
        cmp(CORE_RST.full, 32'h1, "reset wake is full");
        @(posedge MCLK);
        EXT_RESET <= 1'h0;
    endtask : s_deep
    initial begin
        repeat (6) @(posedge MCLK);
        cmp(PC_ZERO, 32'h1, "counter zero at reset");
        RSTN <= 1'h1;
        s_regs();
        s_sleep();
        s_int();
        s_timeout();
        s_key();
        s_deep();
        close_out();
    end
endmodule : wdw_bench
`default_nettype wire
